// ===== include/bst_pkg.sv
package bst_pkg;
   localparam int IR_W       = 4;
   localparam int BSR_LEN    = 24;
   localparam int ID_W       = 32;
   localparam int RA_ADDR_W  = 7;
   localparam int RA_DATA_W  = 8;
   localparam int RW_LEN     = RA_ADDR_W + RA_DATA_W;
   localparam int N_PINS     = 12;

   localparam logic [3:0] INS_BYPASS = 4'h0;
   localparam logic [3:0] INS_SAMPLE = 4'h1;
   localparam logic [3:0] INS_IDCODE = 4'h2;
   localparam logic [3:0] INS_USER   = 4'h3;
   localparam logic [3:0] INS_CLAMP  = 4'h4;
   localparam logic [3:0] INS_HIGHZ  = 4'h5;
   localparam logic [3:0] INS_EXTEST = 4'h7;
   localparam logic [3:0] INS_IFOFF  = 4'h8;
   localparam logic [3:0] INS_RDREG  = 4'h9;
   localparam logic [3:0] INS_WRREG  = 4'hA;

   // Instruction-register capture pattern fixed by the test standard
   localparam logic [3:0] IR_CAPTURE = 4'h1;

   // Identity fields: values are arbitrary
   localparam logic [3:0]  ID_VERSION = 4'h0;
   localparam logic [15:0] ID_PART    = 16'h1234;
   localparam logic [10:0] ID_MAKER   = 11'h055;

   // Cell positions of the two special cells in the 24-cell chain
   localparam int CELL_LINE3_IN   = 6;
   localparam int CELL_LINE2_OUT2 = 7;

   typedef enum logic [3:0] {
      BST_RESET, BST_IDLE, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR,
      BST_PAU_DR, BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SH_IR,
      BST_EX1_IR, BST_PAU_IR, BST_EX2_IR, BST_UPD_IR
   } bst_state_e;

   // Serial port pins after synchronisation
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bst_link_s;

   // Internal register access request
   typedef struct packed {
      logic                  wr;
      logic                  rd;
      logic [RA_ADDR_W-1:0]  addr;
      logic [RA_DATA_W-1:0]  data;
   } bst_reg_req_s;
endpackage

// ===== src/bst_link_sync.sv
`timescale 1ns/1ps
module bst_link_sync
   import bst_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Raw test pins
   input  wire logic       tck,
   input  wire logic       tms,
   input  wire logic       tdi,
   // Synchronised view and edges
   output bst_pkg::bst_link_s link,
   output logic            tck_rise,
   output logic            tck_fall
);
   import bst_pkg::*;

   bst_link_s s1_ff, s2_ff, nxt_s1, nxt_s2;
   logic      tck_d_ff, nxt_tck_d;

   always_comb begin
      nxt_s1    = '{tck: tck, tms: tms, tdi: tdi};
      nxt_s2    = s1_ff;
      nxt_tck_d = s2_ff.tck;
   end

   // Pull-ups keep idle pins high
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         s1_ff    <= '1;
         s2_ff    <= '1;
         tck_d_ff <= 1'b1;
      end else begin
         s1_ff    <= nxt_s1;
         s2_ff    <= nxt_s2;
         tck_d_ff <= nxt_tck_d;
      end
   end

   assign link     = s2_ff;
   assign tck_rise = s2_ff.tck & ~tck_d_ff;
   assign tck_fall = ~s2_ff.tck & tck_d_ff;
endmodule // bst_link_sync

// ===== src/bst_tap.sv
`timescale 1ns/1ps
// Functional notes
// - Only test clock edges advance state
// - Mode-select sampled on rise picks next state
// - Five high mode-selects reach reset state
// - Reset state loads identification instruction
// - Serial input shifted into selected chain
// - Serial output changes on falling edges
// - Output disabled unless shifting
// - Code 0 selects one-bit bypass
// - Instruction codes decoded as listed
// - Chain length follows active instruction
// - Write shifts address then data byte
// - Boundary chain order cell 23 to 0
// - Control, bidirectional and special cell kinds
// - Identity: version, part, maker, one
// - User code from USER_CODE parameter
// - Interface-off bit taken at data update
// - Read captures, shifts, updates address
module bst_tap
   import bst_pkg::*;
#(
   parameter logic [31:0] USER_CODE = 32'h0000_0000
) (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   // Test pins
   input  wire logic                   tck,
   input  wire logic                   tms,
   input  wire logic                   tdi,
   output logic                        tdo,
   output logic                        tdo_oe_n,
   // Core side of pins: out value, out enable (high), in value
   input  wire logic [N_PINS-1:0]      core_out,
   input  wire logic [N_PINS-1:0]      core_oe,
   input  wire logic [N_PINS-1:0]      pin_in,
   output logic [N_PINS-1:0]           pad_out,
   output logic [N_PINS-1:0]           pad_oe,
   output logic                        line2_out2,
   // Internal register access
   output logic                        host_if_off,
   output bst_pkg::bst_reg_req_s       reg_req,
   input  wire logic [RA_DATA_W-1:0]   reg_rdata
);
   import bst_pkg::*;

   bst_link_s link;
   logic      rise, fall;

   bst_link_sync u_sync (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .tck      (tck),
      .tms      (tms),
      .tdi      (tdi),
      .link     (link),
      .tck_rise (rise),
      .tck_fall (fall)
   );

   bst_state_e           st_ff, nxt_st;
   logic [IR_W-1:0]      ir_sh_ff, nxt_ir_sh, ir_ff, nxt_ir;
   logic [ID_W-1:0]      dr_ff, nxt_dr;
   logic [BSR_LEN-1:0]   upd_ff, nxt_upd;
   logic [RA_ADDR_W-1:0] addr_ff, nxt_addr;
   logic                 ifoff_ff, nxt_ifoff;
   bst_reg_req_s         req_ff, nxt_req;
   logic                 tdo_ff, nxt_tdo, oen_ff, nxt_oen;
   logic [N_PINS-1:0]    pout_ff, nxt_pout, poe_ff, nxt_poe;
   logic                 o2_ff, nxt_o2;

   // Chain length per instruction
   function automatic int dr_len(input logic [IR_W-1:0] ins);
      unique case (ins)
         INS_SAMPLE, INS_EXTEST: dr_len = BSR_LEN;
         INS_IDCODE, INS_USER:   dr_len = ID_W;
         INS_RDREG:              dr_len = RA_ADDR_W;
         INS_WRREG:              dr_len = RW_LEN;
         default:                dr_len = 1;
      endcase
   endfunction

   function automatic bst_state_e tap_next(input bst_state_e s,
                                           input logic m);
      unique case (s)
         BST_RESET:  tap_next = m ? BST_RESET  : BST_IDLE;
         BST_IDLE:   tap_next = m ? BST_SEL_DR : BST_IDLE;
         BST_SEL_DR: tap_next = m ? BST_SEL_IR : BST_CAP_DR;
         BST_CAP_DR: tap_next = m ? BST_EX1_DR : BST_SH_DR;
         BST_SH_DR:  tap_next = m ? BST_EX1_DR : BST_SH_DR;
         BST_EX1_DR: tap_next = m ? BST_UPD_DR : BST_PAU_DR;
         BST_PAU_DR: tap_next = m ? BST_EX2_DR : BST_PAU_DR;
         BST_EX2_DR: tap_next = m ? BST_UPD_DR : BST_SH_DR;
         BST_UPD_DR: tap_next = m ? BST_SEL_DR : BST_IDLE;
         BST_SEL_IR: tap_next = m ? BST_RESET  : BST_CAP_IR;
         BST_CAP_IR: tap_next = m ? BST_EX1_IR : BST_SH_IR;
         BST_SH_IR:  tap_next = m ? BST_EX1_IR : BST_SH_IR;
         BST_EX1_IR: tap_next = m ? BST_UPD_IR : BST_PAU_IR;
         BST_PAU_IR: tap_next = m ? BST_EX2_IR : BST_PAU_IR;
         BST_EX2_IR: tap_next = m ? BST_UPD_IR : BST_SH_IR;
         BST_UPD_IR: tap_next = m ? BST_SEL_DR : BST_IDLE;
      endcase
   endfunction

   logic [BSR_LEN-1:0] cap_bsr;
   logic               boundary_drives;
   int                 len;

   // Cell pairs: even = pin value, odd = its enable (cell 7 captures core_out[4] instead), pin 11 at top
   always_comb begin
      cap_bsr = '0;
      for (int i = 0; i < N_PINS; i++) begin
         cap_bsr[2*i]   = pin_in[i];
         cap_bsr[2*i+1] = core_oe[i];
      end
      cap_bsr[CELL_LINE2_OUT2] = core_out[4];
      // Input-only cell on line 3 captures the pad
      cap_bsr[CELL_LINE3_IN] = pin_in[3];
   end

   assign len = dr_len(ir_ff);
   assign boundary_drives = (ir_ff == INS_EXTEST) || (ir_ff == INS_CLAMP);

   always_comb begin
      nxt_st    = st_ff;
      nxt_ir_sh = ir_sh_ff;
      nxt_ir    = ir_ff;
      nxt_dr    = dr_ff;
      nxt_upd   = upd_ff;
      nxt_addr  = addr_ff;
      nxt_ifoff = ifoff_ff;
      nxt_req   = '{wr: 1'b0, rd: 1'b0, addr: req_ff.addr,
                    data: req_ff.data};
      nxt_tdo   = tdo_ff;
      nxt_oen   = oen_ff;
      // State holds without test clock edges
      if (rise) begin
         nxt_st = tap_next(st_ff, link.tms);
         unique case (st_ff)
            BST_RESET: nxt_ir = INS_IDCODE;
            BST_CAP_IR: nxt_ir_sh = IR_CAPTURE;
            BST_SH_IR: nxt_ir_sh = {link.tdi, ir_sh_ff[IR_W-1:1]};
            BST_UPD_IR: nxt_ir = ir_sh_ff;
            BST_CAP_DR: begin
               unique case (ir_ff)
                  INS_SAMPLE, INS_EXTEST:
                     nxt_dr = {{(ID_W-BSR_LEN){1'b0}}, cap_bsr};
                  INS_IDCODE: nxt_dr = {ID_VERSION, ID_PART, ID_MAKER,
                                        1'b1};
                  INS_USER:   nxt_dr = USER_CODE;
                  INS_RDREG:  nxt_dr = {{(ID_W-RA_ADDR_W){1'b0}},
                                        addr_ff};
                  default:    nxt_dr = '0;
               endcase
            end
            BST_SH_DR: begin
               nxt_dr = dr_ff >> 1;
               nxt_dr[len-1] = link.tdi;
            end
            BST_UPD_DR: begin
               unique case (ir_ff)
                  INS_SAMPLE, INS_EXTEST: nxt_upd = dr_ff[BSR_LEN-1:0];
                  INS_IFOFF: nxt_ifoff = dr_ff[0];
                  INS_RDREG: begin
                     nxt_addr = dr_ff[RA_ADDR_W-1:0];
                     nxt_req.rd   = ifoff_ff;
                     nxt_req.addr = dr_ff[RA_ADDR_W-1:0];
                  end
                  INS_WRREG: begin
                     // Address shifted first, so sits in the low bits
                     nxt_req.wr   = ifoff_ff;
                     nxt_req.addr = dr_ff[RA_ADDR_W-1:0];
                     nxt_req.data = dr_ff[RW_LEN-1:RA_ADDR_W];
                     nxt_addr     = dr_ff[RA_ADDR_W-1:0];
                  end
                  default: ;
               endcase
            end
            default: ;
         endcase
         if (nxt_st == BST_RESET)
            nxt_ir = INS_IDCODE;
      end
      if (fall) begin
         nxt_oen = 1'b1;
         if (st_ff == BST_SH_IR) begin
            nxt_tdo = ir_sh_ff[0];
            nxt_oen = 1'b0;
         end else if (st_ff == BST_SH_DR) begin
            nxt_tdo = dr_ff[0];
            nxt_oen = 1'b0;
         end
      end
   end

   // Pin muxing from the update stage of the boundary chain
   always_comb begin
      nxt_pout = core_out;
      nxt_poe  = core_oe;
      nxt_o2   = core_out[4];
      if (boundary_drives) begin
         for (int i = 0; i < N_PINS; i++) begin
            nxt_pout[i] = upd_ff[2*i];
            nxt_poe[i]  = upd_ff[2*i+1];
         end
         nxt_o2 = upd_ff[CELL_LINE2_OUT2];
      end else if (ir_ff == INS_HIGHZ) begin
         nxt_poe = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_ff    <= BST_RESET;
         ir_sh_ff <= '0;
         ir_ff    <= INS_IDCODE;
         dr_ff    <= '0;
         upd_ff   <= '0;
         addr_ff  <= '0;
         ifoff_ff <= 1'b0;
         req_ff   <= '0;
         tdo_ff   <= 1'b0;
         oen_ff   <= 1'b1;
         pout_ff  <= '0;
         poe_ff   <= '0;
         o2_ff    <= 1'b0;
      end else begin
         st_ff    <= nxt_st;
         ir_sh_ff <= nxt_ir_sh;
         ir_ff    <= nxt_ir;
         dr_ff    <= nxt_dr;
         upd_ff   <= nxt_upd;
         addr_ff  <= nxt_addr;
         ifoff_ff <= nxt_ifoff;
         req_ff   <= nxt_req;
         tdo_ff   <= nxt_tdo;
         oen_ff   <= nxt_oen;
         pout_ff  <= nxt_pout;
         poe_ff   <= nxt_poe;
         o2_ff    <= nxt_o2;
      end
   end

   assign tdo         = tdo_ff;
   assign tdo_oe_n    = oen_ff;
   assign pad_out     = pout_ff;
   assign pad_oe      = poe_ff;
   assign line2_out2  = o2_ff;
   assign host_if_off = ifoff_ff;
   assign reg_req     = req_ff;

   // Helper: consecutive high mode-select samples
   logic [2:0] tms_hi;
   always_ff @(posedge mclk) begin
      if (!rst_n)
         tms_hi <= '0;
      else if (rise)
         tms_hi <= link.tms ? ((tms_hi == 3'h5) ? tms_hi : tms_hi + 3'h1)
                            : 3'h0;
   end

   a_five_ones_reset: assert property (@(posedge mclk) disable iff (!rst_n)
      (tms_hi == 3'h5) |-> st_ff == BST_RESET)
      else $error("five high samples did not reach reset");
   a_reset_loads_id: assert property (@(posedge mclk) disable iff (!rst_n)
      (st_ff == BST_RESET) |-> ir_ff == INS_IDCODE)
      else $error("reset state without id instruction");
   a_state_holds: assert property (@(posedge mclk) disable iff (!rst_n)
      !rise |=> $stable(st_ff))
      else $error("state moved without clock rise");
   a_tdo_on_fall: assert property (@(posedge mclk) disable iff (!rst_n)
      !fall |=> $stable(tdo_ff) && $stable(oen_ff))
      else $error("serial output changed off falling edge");
   a_tdo_idle_off: assert property (@(posedge mclk) disable iff (!rst_n)
      fall && st_ff != BST_SH_DR && st_ff != BST_SH_IR |=> oen_ff)
      else $error("serial output driven while not shifting");
   a_id_lsb_one: assert property (@(posedge mclk) disable iff (!rst_n)
      rise && st_ff == BST_CAP_DR && ir_ff == INS_IDCODE |=> dr_ff[0])
      else $error("identity lsb not one");
   a_ifoff_update: assert property (@(posedge mclk) disable iff (!rst_n)
      rise && st_ff == BST_UPD_DR && ir_ff == INS_IFOFF
      |=> ifoff_ff == $past(dr_ff[0]))
      else $error("interface bit not taken at update");
   a_highz_off: assert property (@(posedge mclk) disable iff (!rst_n)
      ir_ff == INS_HIGHZ |=> pad_oe == '0)
      else $error("pins enabled under high impedance");
   a_tms_sampled: assert property (@(posedge mclk) disable iff (!rst_n)
      rise |=> st_ff == tap_next($past(st_ff), $past(link.tms)))
      else $error("next state not from sampled mode-select");
   a_req_needs_off: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_req.wr || reg_req.rd |-> host_if_off)
      else $error("register request while interface still on");
endmodule // bst_tap

// ===== tb/bst_jtag_model.sv
`timescale 1ns/1ps
module bst_jtag_model (
   // Clock
   input  wire logic mclk,
   // Test pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe_n
);
   logic oe_bad;

   // Pull-ups: pins idle high, clock stands still between frames
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b1;
      oe_bad = 1'b0;
   end

   // One 80 ns test clock; output read late in the low phase
   task automatic clk(input logic m, input logic d, output logic q,
                      output logic o);
      @(negedge mclk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (5) @(negedge mclk);
      // Released line shows the inverse, so an off-drive read is caught
      q = (tdo_oe_n === 1'b0) ? tdo : ~tdo;
      o = tdo_oe_n;
      tck <= 1'b1;
      repeat (4) @(negedge mclk);
   endtask

   task automatic shift(input int n, input logic [31:0] din,
                        output logic [31:0] dout);
      logic q;
      logic o;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         clk(i == n - 1, din[i], q, o);
         dout[i] = q;
         if (o !== 1'b0) oe_bad = 1'b1;
      end
      clk(1'b1, 1'b1, q, o);
      clk(1'b0, 1'b1, q, o);
      if (o !== 1'b1) oe_bad = 1'b1;
   endtask

   task automatic reset5();
      logic q;
      logic o;
      repeat (5) clk(1'b1, 1'b1, q, o);
      clk(1'b0, 1'b1, q, o);
   endtask

   task automatic ir(input logic [3:0] code, output logic [3:0] cap);
      logic [31:0] r;
      logic q;
      logic o;
      clk(1'b1, 1'b1, q, o);
      clk(1'b1, 1'b1, q, o);
      clk(1'b0, 1'b1, q, o);
      clk(1'b0, 1'b1, q, o);
      shift(4, {28'h0, code}, r);
      cap = r[3:0];
   endtask

   task automatic dr(input int n, input logic [31:0] din,
                     output logic [31:0] dout);
      logic q;
      logic o;
      clk(1'b1, 1'b1, q, o);
      clk(1'b0, 1'b1, q, o);
      clk(1'b0, 1'b1, q, o);
      shift(n, din, dout);
   endtask
endmodule // bst_jtag_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import bst_pkg::*;
   localparam logic [31:0] UC = 32'hA5C3_0F1E;
   logic                  mclk, rst_n, tck, tms, tdi, tdo, tdo_oe_n;
   logic [N_PINS-1:0]     core_out, core_oe, pin_in, pad_out, pad_oe;
   logic                  line2_out2, host_if_off;
   bst_reg_req_s          reg_req;
   logic [31:0]           d;
   logic [3:0]            cap;
   logic [6:0]            wr_a;
   logic [6:0]            rd_a;
   logic [7:0]            wr_d;
   int                    err_total, check_count, wr_n, rd_n;

   bst_tap #(.USER_CODE(UC)) i_bst_tap (.mclk(mclk), .rst_n(rst_n),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
      .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .line2_out2(line2_out2),
      .host_if_off(host_if_off), .reg_req(reg_req), .reg_rdata(8'h00));
   bst_jtag_model i_bst_jtag_model (.mclk(mclk), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));

   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   always @(posedge mclk) begin
      if (reg_req.wr === 1'b1) begin
         wr_n++;
         wr_a = reg_req.addr;
         wr_d = reg_req.data;
      end
      if (reg_req.rd === 1'b1) begin
         rd_n++;
         rd_a = reg_req.addr;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic set_pins(input logic i, input logic e, input logic o);
      @(negedge mclk);
      pin_in <= {N_PINS{i}};
      core_oe <= {N_PINS{e}};
      core_out <= {N_PINS{o}};
   endtask

   // Reset from inside Shift-DR under bypass, then identity is back
   task automatic t_id();
      logic q;
      logic o;
      i_bst_jtag_model.clk(1'b0, 1'b1, q, o);
      i_bst_jtag_model.ir(INS_BYPASS, cap);
      i_bst_jtag_model.clk(1'b1, 1'b1, q, o);
      i_bst_jtag_model.clk(1'b0, 1'b1, q, o);
      i_bst_jtag_model.clk(1'b0, 1'b1, q, o);
      i_bst_jtag_model.reset5();
      i_bst_jtag_model.dr(32, 32'h0, d);
      chk(d, {ID_VERSION, ID_PART, ID_MAKER, 1'b1});
   endtask

   task automatic t_bypass();
      i_bst_jtag_model.ir(INS_BYPASS, cap);
      chk(cap, IR_CAPTURE);
      i_bst_jtag_model.dr(8, 32'hB5, d);
      chk(d, 32'h6A);
   endtask

   // Clock parked high for a long spell between instruction and data
   task automatic t_user();
      i_bst_jtag_model.ir(INS_USER, cap);
      repeat (100) @(negedge mclk);
      i_bst_jtag_model.dr(32, 32'h0, d);
      chk(d, UC);
   endtask

   // Cell 6 masked: its pad source is not pinned down by value alone
   task automatic t_sample();
      set_pins(1'b1, 1'b1, 1'b1);
      i_bst_jtag_model.ir(INS_SAMPLE, cap);
      i_bst_jtag_model.dr(24, 32'h0, d);
      chk(d, 32'hFF_FFFF);
      set_pins(1'b1, 1'b0, 1'b0);
      i_bst_jtag_model.dr(24, 32'h0, d);
      chk(d & ~32'h40, 32'h55_5515);
      chk(pad_out, core_out);
   endtask

   task automatic t_drive();
      set_pins(1'b0, 1'b1, 1'b1);
      i_bst_jtag_model.dr(24, 32'h0, d);
      i_bst_jtag_model.ir(INS_EXTEST, cap);
      chk({line2_out2, pad_out}, 32'h0);
      i_bst_jtag_model.ir(INS_SAMPLE, cap);
      i_bst_jtag_model.dr(24, 32'hFF_FFFF, d);
      i_bst_jtag_model.ir(INS_CLAMP, cap);
      chk({line2_out2, pad_out}, {(N_PINS+1){1'b1}});
      i_bst_jtag_model.dr(8, 32'hB5, d);
      chk(d, 32'h6A);
      i_bst_jtag_model.ir(INS_HIGHZ, cap);
      chk(pad_oe, '0);
      i_bst_jtag_model.dr(8, 32'hB5, d);
      chk(d, 32'h6A);
   endtask

   // Write refused until the interface-off bit is set
   task automatic t_reg();
      wr_n = 0;
      i_bst_jtag_model.ir(INS_WRREG, cap);
      i_bst_jtag_model.dr(RW_LEN, {17'h0, 8'hC3, 7'h5A}, d);
      chk(wr_n, 0);
      i_bst_jtag_model.ir(INS_IFOFF, cap);
      i_bst_jtag_model.dr(1, 32'h1, d);
      chk(host_if_off, 1'b1);
      i_bst_jtag_model.ir(INS_WRREG, cap);
      i_bst_jtag_model.dr(RW_LEN, {17'h0, 8'hC3, 7'h5A}, d);
      chk(wr_n, 1);
      chk({wr_d, wr_a}, {8'hC3, 7'h5A});
      i_bst_jtag_model.ir(INS_RDREG, cap);
      i_bst_jtag_model.dr(RA_ADDR_W, 32'h21, d);
      chk(rd_n, 1);
      chk(rd_a, 7'h21);
      i_bst_jtag_model.dr(RA_ADDR_W, 32'h00, d);
      chk(d, 32'h21);
   endtask

   initial begin
      err_total = 0;
      check_count = 0;
      wr_n = 0;
      rd_n = 0;
      rst_n = 1'b0;
      core_out = '0;
      core_oe = '0;
      pin_in = '0;
      repeat (20) @(negedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(negedge mclk);
      t_id();
      t_bypass();
      t_user();
      t_sample();
      t_drive();
      t_reg();
      chk(i_bst_jtag_model.oe_bad, 1'b0);
      final_report();
   end

   // Whole run is near 4400 cycles; a hang is cut off well after
   initial begin
      repeat (60000) @(posedge mclk);
      err_total++;
      final_report();
   end
endmodule // tb_top
